/* hdl/capture_map.svh */
// Register offsets, field positions, reset values and counts of the capture channel
`ifndef CAPTURE_MAP_SVH
`define CAPTURE_MAP_SVH

`define CAP_CTRL_OFS        12'h000
`define CAP_STAT_OFS        12'h004
`define CAP_IRQ_STAT_OFS    12'h008
`define CAP_IRQ_MASK_OFS    12'h00c
`define CAP_DATA_OFS        12'h010

`define CAP_CTRL_ON_BIT     0
`define CAP_CTRL_MODE_LSB   1
`define CAP_CTRL_FIRST_BIT  4
`define CAP_CTRL_TSEL_LSB   5
`define CAP_CTRL_THR_LSB    7
`define CAP_CTRL_WAKE_BIT   9
`define CAP_CTRL_RST        32'h0000_0000

`define CAP_IRQ_THR_BIT     0
`define CAP_IRQ_OVF_BIT     1
`define CAP_IRQ_EDGE_BIT    2
`define CAP_IRQ_RST         3'h0

`define CAP_DIV4_COUNT      5'h04
`define CAP_DIV16_COUNT     5'h10
`define CAP_FIFO_DEPTH      3'h4

`endif

/* hdl/capture_pkg.sv */
// Types of the capture channel
package capture_pkg;

	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_FALL,
		MODE_RISE,
		MODE_EVERY,
		MODE_EVERY_FIRST,
		MODE_DIV4,
		MODE_DIV16,
		MODE_EDGE_ONLY
	} cap_mode_t;

	typedef enum logic [1:0] {
		TB_A,
		TB_B,
		TB_CASCADE,
		TB_SPARE
	} tb_sel_t;

	typedef struct packed {
		logic [31:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic        wake_en;
		logic [1:0]  threshold;
		tb_sel_t     tb_sel;
		logic        first_rise;
		cap_mode_t   mode;
		logic        on;
	} cap_ctrl_t;

endpackage

/* hdl/input_capture_channel.sv */
// One input capture channel with APB registers, four-entry FIFO and interrupt
//
// Added by the designer: the register addresses and register access over APB.
`include "capture_map.svh"
`timescale 1ns/100ps
`default_nettype none

module input_capture_channel (
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_resetn,
	input  wire logic                  i_clk_en,
	// APB slave
	input  wire capture_pkg::apb_req_t i_apb,
	output capture_pkg::apb_rsp_t      o_apb,
	// Time bases and capture pin
	input  wire logic [15:0]           i_time_base_a,
	input  wire logic [15:0]           i_time_base_b,
	input  wire logic                  i_capture_input_pin,
	// Interrupt and wake
	output logic                       o_irq,
	output logic                       o_wake
);

	localparam int DEPTH = 4;

	// Synchroniser and edge history
	logic       pin_meta;
	logic       pin_sync;
	logic       pin_prev;
	logic       next_pin_meta;
	logic       next_pin_sync;
	logic       next_pin_prev;

	// Control and status
	capture_pkg::cap_ctrl_t ctrl;
	capture_pkg::cap_ctrl_t next_ctrl;
	logic [2:0]             irq_stat;
	logic [2:0]             next_irq_stat;
	logic [2:0]             irq_mask;
	logic [2:0]             next_irq_mask;
	logic [4:0]             pre_cnt;
	logic [4:0]             next_pre_cnt;
	logic                   armed;
	logic                   next_armed;
	logic [31:0]            rdata;
	logic [31:0]            next_rdata;

	// FIFO
	logic [31:0] fifo_mem [DEPTH];
	logic [31:0] next_fifo_mem [DEPTH];
	logic [1:0]  wr_ptr;
	logic [1:0]  next_wr_ptr;
	logic [1:0]  rd_ptr;
	logic [1:0]  next_rd_ptr;
	logic [2:0]  count;
	logic [2:0]  next_count;

	logic        rise;
	logic        fall;
	logic        event_hit;
	logic        push;
	logic        pop;
	logic        full;
	logic        wr_acc;
	logic        rd_acc;
	logic        rd_set;
	logic        pop_ok;
	logic        next_pop_ok;
	logic [31:0] sample;

	function automatic logic reg_hit(input logic [31:0] addr, input logic [11:0] ofs);
		reg_hit = (addr[11:2] == ofs[11:2]) && (addr[31:12] == 20'h0_0000);
	endfunction

	assign rise   = pin_sync & ~pin_prev;
	assign fall   = ~pin_sync & pin_prev;
	assign full   = (count == `CAP_FIFO_DEPTH);
	assign wr_acc = i_apb.psel & i_apb.penable & i_apb.pwrite;
	assign rd_acc = i_apb.psel & i_apb.penable & ~i_apb.pwrite;
	assign rd_set = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
	// Pop only on the access edge, and only if the word was there at setup
	assign pop    = rd_acc && pop_ok;

	// Time base chosen by tb_sel; timers may run on any clock, only values matter
	always_comb begin
		unique case (ctrl.tb_sel)
			capture_pkg::TB_A:       sample = {16'h0000, i_time_base_a};
			capture_pkg::TB_B:       sample = {16'h0000, i_time_base_b};
			capture_pkg::TB_CASCADE: sample = {i_time_base_b, i_time_base_a};
			default:                 sample = {16'h0000, i_time_base_a};
		endcase
	end

	// Event selection
	always_comb begin
		next_pre_cnt = pre_cnt;
		next_armed   = armed;
		event_hit    = 1'b0;
		if (!ctrl.on) begin
			next_pre_cnt = 5'h00;
			next_armed   = 1'b0;
		end else begin
			unique case (ctrl.mode)
				capture_pkg::MODE_OFF:       event_hit = 1'b0;
				capture_pkg::MODE_FALL:      event_hit = fall;
				capture_pkg::MODE_RISE:      event_hit = rise;
				capture_pkg::MODE_EVERY:     event_hit = rise | fall;
				capture_pkg::MODE_EDGE_ONLY: event_hit = rise | fall;
				capture_pkg::MODE_EVERY_FIRST: begin
					if (armed) begin
						event_hit = rise | fall;
					end else if (ctrl.first_rise ? rise : fall) begin
						event_hit  = 1'b1;
						next_armed = 1'b1;
					end
				end
				capture_pkg::MODE_DIV4, capture_pkg::MODE_DIV16: begin
					if (rise) begin
						if (next_pre_cnt_limit(ctrl.mode, pre_cnt)) begin
							event_hit    = 1'b1;
							next_pre_cnt = 5'h00;
						end else begin
							next_pre_cnt = pre_cnt + 5'h01;
						end
					end
				end
			endcase
		end
	end

	function automatic logic next_pre_cnt_limit(input capture_pkg::cap_mode_t m,
		input logic [4:0] c);
		if (m == capture_pkg::MODE_DIV4) begin
			next_pre_cnt_limit = (c == (`CAP_DIV4_COUNT - 5'h01));
		end else begin
			next_pre_cnt_limit = (c == (`CAP_DIV16_COUNT - 5'h01));
		end
	endfunction

	// Edge-only mode raises the interrupt but stores nothing
	assign push = event_hit && (ctrl.mode != capture_pkg::MODE_EDGE_ONLY) && !full;

	// One load decoder per entry; only the slot under the write pointer loads
	generate
		for (genvar g = 0; g < DEPTH; g++) begin : g_entry
			always_comb begin
				next_fifo_mem[g] = fifo_mem[g];
				if (push && (wr_ptr == 2'(g))) begin
					next_fifo_mem[g] = sample;
				end
			end
		end
	endgenerate

	// FIFO pointers and fill count
	always_comb begin
		next_wr_ptr   = wr_ptr;
		next_rd_ptr   = rd_ptr;
		next_count    = count;
		if (push) begin
			next_wr_ptr = wr_ptr + 2'h1;
		end
		if (pop) begin
			next_rd_ptr = rd_ptr + 2'h1;
		end
		if (push && !pop) begin
			next_count = count + 3'h1;
		end else if (pop && !push) begin
			next_count = count - 3'h1;
		end
	end

	// Registers, sticky flags and read data
	always_comb begin
		logic [2:0] set_bits;
		set_bits      = 3'h0;
		next_ctrl     = ctrl;
		next_irq_mask = irq_mask;
		next_rdata    = rdata;
		next_pop_ok   = pop_ok;
		// Threshold is a level condition; re-sets every cycle until drained
		set_bits[`CAP_IRQ_THR_BIT]  = ctrl.on && (count >= ({1'b0, ctrl.threshold} + 3'h1));
		set_bits[`CAP_IRQ_OVF_BIT]  = event_hit && full &&
			(ctrl.mode != capture_pkg::MODE_EDGE_ONLY);
		set_bits[`CAP_IRQ_EDGE_BIT] = event_hit;
		next_irq_stat = irq_stat;
		if (wr_acc && reg_hit(i_apb.paddr, `CAP_IRQ_STAT_OFS)) begin
			next_irq_stat = irq_stat & ~i_apb.pwdata[2:0];
		end
		// Set wins over a clearing write in the same cycle
		next_irq_stat = next_irq_stat | set_bits;
		if (wr_acc && reg_hit(i_apb.paddr, `CAP_CTRL_OFS)) begin
			next_ctrl = i_apb.pwdata[9:0];
		end
		if (wr_acc && reg_hit(i_apb.paddr, `CAP_IRQ_MASK_OFS)) begin
			next_irq_mask = i_apb.pwdata[2:0];
		end
		// Read data is taken in setup so that it stands through the access cycle
		if (rd_set) begin
			next_pop_ok = reg_hit(i_apb.paddr, `CAP_DATA_OFS) && (count != 3'h0);
			if (reg_hit(i_apb.paddr, `CAP_CTRL_OFS)) begin
				next_rdata = {22'h00_0000, ctrl};
			end else if (reg_hit(i_apb.paddr, `CAP_STAT_OFS)) begin
				next_rdata = {28'h000_0000, full, count};
			end else if (reg_hit(i_apb.paddr, `CAP_IRQ_STAT_OFS)) begin
				next_rdata = {29'h0000_0000, irq_stat};
			end else if (reg_hit(i_apb.paddr, `CAP_IRQ_MASK_OFS)) begin
				next_rdata = {29'h0000_0000, irq_mask};
			end else if (reg_hit(i_apb.paddr, `CAP_DATA_OFS)) begin
				next_rdata = fifo_mem[rd_ptr];
			end else begin
				next_rdata = 32'h0000_0000;
			end
		end else if (rd_acc) begin
			next_pop_ok = 1'b0;
		end
	end

	// Two-flop synchroniser, then one history stage for edge detection
	always_comb begin
		next_pin_meta = i_capture_input_pin;
		next_pin_sync = pin_meta;
		next_pin_prev = pin_sync;
	end

	// Frozen with the rest, so an edge seen while disabled is kept, not lost
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else if (i_clk_en) begin
			pin_meta <= next_pin_meta;
			pin_sync <= next_pin_sync;
			pin_prev <= next_pin_prev;
		end
	end

	// Control, status and read data
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl     <= 10'(`CAP_CTRL_RST);
			irq_stat <= `CAP_IRQ_RST;
			irq_mask <= `CAP_IRQ_RST;
			pre_cnt  <= 5'h00;
			armed    <= 1'b0;
			rdata    <= 32'h0000_0000;
			pop_ok   <= 1'b0;
		end else if (i_clk_en) begin
			ctrl     <= next_ctrl;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			pre_cnt  <= next_pre_cnt;
			armed    <= next_armed;
			rdata    <= next_rdata;
			pop_ok   <= next_pop_ok;
		end
	end

	// FIFO storage and pointers
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr   <= 2'h0;
			rd_ptr   <= 2'h0;
			count    <= 3'h0;
			for (int i = 0; i < DEPTH; i++) begin
				fifo_mem[i] <= 32'h0000_0000;
			end
		end else if (i_clk_en) begin
			wr_ptr   <= next_wr_ptr;
			rd_ptr   <= next_rd_ptr;
			count    <= next_count;
			fifo_mem <= next_fifo_mem;
		end
	end

	// Zero-wait slave; read data loaded in setup, so it stands when pready is seen
	always_comb begin
		o_apb.pready  = 1'b1;
		o_apb.pslverr = 1'b0;
		o_apb.prdata  = rdata;
	end

	assign o_irq  = |(irq_stat & irq_mask);
	// Wake is combinational from the synchronised pin edges, so it needs i_clk_en to see a new edge
	assign o_wake = ctrl.on && ctrl.wake_en && (rise | fall);

endmodule

`default_nettype wire

/* sim/input_capture_channel_properties.sv */
// Port assertions of the capture channel
`timescale 1ns/100ps
`default_nettype none

module input_capture_channel_properties (
	input wire logic                  i_clk,
	input wire logic                  i_resetn,
	input wire logic                  i_clk_en,
	input wire capture_pkg::apb_req_t i_apb,
	input wire capture_pkg::apb_rsp_t o_apb,
	input wire logic [15:0]           i_time_base_a,
	input wire logic [15:0]           i_time_base_b,
	input wire logic                  i_capture_input_pin,
	input wire logic                  o_irq,
	input wire logic                  o_wake
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	capture_pkg::cap_ctrl_t ctrl;
	logic [2:0]             mask;
	logic                   wr;
	logic                   rdacc;
	logic                   rdset;
	logic                   p;
	assign p = i_capture_input_pin;
	assign wr = i_clk_en & i_apb.psel & i_apb.penable & i_apb.pwrite & o_apb.pready;
	assign rdset = i_clk_en & i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
	assign rdacc = i_apb.psel & i_apb.penable & ~i_apb.pwrite;
	// Shadows updated at the same edge as the registers
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl <= '0;
			mask <= '0;
		end else if (wr && i_apb.paddr == 32'h0)
			ctrl <= capture_pkg::cap_ctrl_t'(i_apb.pwdata[9:0]);
		else if (wr && i_apb.paddr == 32'hc)
			mask <= i_apb.pwdata[2:0];
	end
	AST_WAKE_OFF: assert property (!(ctrl.on && ctrl.wake_en) |-> !o_wake)
		else $error("wake while disabled");
	AST_WAKE_CAUSE: assert property (o_wake |->
		$past(p, 2) != $past(p, 3) || $past(p, 3) != $past(p, 4))
		else $error("wake without pin edge");
	AST_WAKE_ONCE: assert property (o_wake |=> !o_wake)
		else $error("wake longer than one cycle");
	AST_WAKE_EVERY: assert property (ctrl.on && ctrl.wake_en && ctrl.mode == capture_pkg::MODE_EVERY
		&& $past(p, 1) != $past(p, 2) |-> ##[0:3] o_wake)
		else $error("edge missed");
	AST_EDGE_IRQ: assert property (ctrl.mode == capture_pkg::MODE_EDGE_ONLY
		&& o_wake && mask[2] |=> o_irq)
		else $error("edge interrupt missing");
	AST_IRQ_MASK: assert property (mask == 3'h0 |-> !o_irq)
		else $error("interrupt while masked");
	AST_IRQ_HOLD: assert property (o_irq && !wr |=> o_irq)
		else $error("interrupt dropped without write");
	AST_PRDATA_HOLD: assert property (!rdset |=> $stable(o_apb.prdata))
		else $error("read data changed without read");
	COV_WAKE: cover property (o_wake);
	COV_IRQ: cover property ($rose(o_irq));
	COV_READ: cover property (rdacc);
endmodule

bind input_capture_channel input_capture_channel_properties chk (.i_clk, .i_resetn, .i_clk_en,
	.i_apb, .o_apb, .i_time_base_a, .i_time_base_b, .i_capture_input_pin, .o_irq, .o_wake);

`default_nettype wire

/* sim/input_capture_channel_tb_top.sv */
// Bench for the input capture channel
`include "capture_map.svh"
`timescale 1ns/100ps
`default_nettype none

module input_capture_channel_tb_top;
	logic                  i_clk = 1'b0;
	logic                  i_resetn = 1'b0;
	capture_pkg::apb_req_t rq = '0;
	capture_pkg::apb_rsp_t rs;
	logic [15:0]           ta = '0;
	logic [15:0]           tbv = '0;
	logic                  pin;
	logic [31:0]           rdat = '0;
	logic                  o_irq;
	logic                  o_wake;
	int                    n_fail = 0;
	int                    samples_checked = 0;
	int                    tn = 0;
	always #2.5 i_clk = ~i_clk;
	input_capture_channel dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_clk_en(1'b1), .i_apb(rq),
		.o_apb(rs), .i_time_base_a(ta), .i_time_base_b(tbv), .i_capture_input_pin(pin),
		.o_irq(o_irq), .o_wake(o_wake));
	pin_source src (.i_clk(i_clk), .o_pin(pin));
	task automatic results();
		$display("Checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read data is taken at the edge at which pready is seen high
	task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d);
		int k;
		rq <= '{{20'h0, a}, 1'b1, 1'b0, w, d};
		@(posedge i_clk);
		rq.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (rs.pready !== 1'b1 && k < 50);
		if (rs.pready !== 1'b1) begin
			n_fail++;
			results();
		end
		rdat = rs.prdata;
		rq.psel <= 1'b0;
		rq.penable <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		acc(a, 1'b0, 32'h0);
		chk(rdat, exp);
	endtask
	// Time bases held steady around each edge so the sample is exact
	task automatic ev(input logic [15:0] v);
		ta <= v;
		tbv <= ~v;
		src.flip();
		repeat (6) @(posedge i_clk);
	endtask
	function automatic logic [31:0] cf(input capture_pkg::cap_mode_t m,
		input capture_pkg::tb_sel_t s, input logic [1:0] t, input logic f);
		return {22'h0, 1'b1, t, s, f, m, 1'b1};
	endfunction
	task automatic go(input logic [31:0] cfg, input int n, input logic [31:0] st);
		if (tn > 0)
			$display("Test %0d done", tn);
		tn++;
		acc(`CAP_CTRL_OFS, 1'b1, 32'h0);
		acc(`CAP_IRQ_STAT_OFS, 1'b1, 32'h7);
		acc(`CAP_CTRL_OFS, 1'b1, cfg);
		for (int i = 1; i <= n; i++)
			ev(16'(i));
		rd(`CAP_STAT_OFS, st);
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		rd(`CAP_CTRL_OFS, 32'h0);
		rd(12'h020, 32'h0);
		go(cf(capture_pkg::MODE_FALL, capture_pkg::TB_A, 2'h0, 1'b0), 4, 32'h2);
		rd(`CAP_DATA_OFS, 32'h2);
		rd(`CAP_DATA_OFS, 32'h4);
		go(cf(capture_pkg::MODE_RISE, capture_pkg::TB_B, 2'h0, 1'b0), 4, 32'h2);
		rd(`CAP_DATA_OFS, 32'hfffe);
		rd(`CAP_DATA_OFS, 32'hfffc);
		acc(`CAP_IRQ_MASK_OFS, 1'b1, 32'h2);
		go(cf(capture_pkg::MODE_EVERY, capture_pkg::TB_CASCADE, 2'h0, 1'b0), 6, 32'hc);
		chk(o_irq, 1'b1);
		for (int i = 1; i <= 4; i++)
			rd(`CAP_DATA_OFS, {~16'(i), 16'(i)});
		go(cf(capture_pkg::MODE_EVERY_FIRST, capture_pkg::TB_A, 2'h0, 1'b0), 4, 32'h3);
		for (int i = 2; i <= 4; i++)
			rd(`CAP_DATA_OFS, 32'(i));
		go(cf(capture_pkg::MODE_EVERY_FIRST, capture_pkg::TB_A, 2'h0, 1'b1), 4, 32'hc);
		for (int i = 1; i <= 4; i++)
			rd(`CAP_DATA_OFS, 32'(i));
		go(cf(capture_pkg::MODE_DIV4, capture_pkg::TB_SPARE, 2'h0, 1'b0), 8, 32'h1);
		rd(`CAP_DATA_OFS, 32'h7);
		go(cf(capture_pkg::MODE_DIV16, capture_pkg::TB_A, 2'h0, 1'b0), 32, 32'h1);
		rd(`CAP_DATA_OFS, 32'h1f);
		acc(`CAP_IRQ_MASK_OFS, 1'b1, 32'h1);
		go(cf(capture_pkg::MODE_RISE, capture_pkg::TB_A, 2'h1, 1'b0), 2, 32'h1);
		chk(o_irq, 1'b0);
		ev(16'h3);
		ev(16'h4);
		chk(o_irq, 1'b1);
		rd(`CAP_DATA_OFS, 32'h1);
		rd(`CAP_DATA_OFS, 32'h3);
		acc(`CAP_IRQ_STAT_OFS, 1'b1, 32'h1);
		chk(o_irq, 1'b0);
		acc(`CAP_IRQ_MASK_OFS, 1'b1, 32'h4);
		go(cf(capture_pkg::MODE_EDGE_ONLY, capture_pkg::TB_A, 2'h0, 1'b0), 2, 32'h0);
		chk(o_irq, 1'b1);
		acc(`CAP_IRQ_STAT_OFS, 1'b1, 32'h4);
		chk(o_irq, 1'b0);
		$display("Test %0d done", tn);
		results();
	end
endmodule

`default_nettype wire

/* sim/pin_source.sv */
// Signal source driving the capture pin
`timescale 1ns/100ps
`default_nettype none

module pin_source (
	// Clock
	input  wire logic i_clk,
	// Capture pin
	output var logic  o_pin
);
	initial o_pin = 1'b0;
	// Flips just after the next edge, so each level stands whole cycles
	task automatic flip();
		@(posedge i_clk);
		o_pin <= ~o_pin;
	endtask
endmodule

`default_nettype wire
